// File: rtl/mts_pkg.sv
// Purpose: shared constants and types of the measurement trigger sequencer
// Assumes: 32-bit AHB-Lite register window, 100 MHz system clock
// Notes: register offsets are byte addresses inside the slave window
package mts_pkg;
  // register offsets
  localparam logic [7:0] MTS_OFS_CTRL = 8'h00;
  localparam logic [7:0] MTS_OFS_DELAY = 8'h04;
  localparam logic [7:0] MTS_OFS_CMD = 8'h08;
  localparam logic [7:0] MTS_OFS_STAT = 8'h0c;
  localparam logic [7:0] MTS_OFS_STR0 = 8'h10;
  localparam logic [7:0] MTS_OFS_STR1 = 8'h14;
  localparam logic [7:0] MTS_OFS_STR2 = 8'h18;
  localparam logic [7:0] MTS_OFS_RAW = 8'h1c;
  // field positions
  localparam int MTS_CTRL_CONT = 0;
  localparam int MTS_CTRL_EXT = 1;
  localparam int MTS_CTRL_DLY = 2;
  localparam int MTS_CMD_ARM = 0;
  localparam int MTS_CMD_FIRE = 1;
  localparam int MTS_CMD_READ = 2;
  localparam int MTS_CMD_CLR = 3;
  localparam logic [2:0] MTS_HSIZE_WORD = 3'h2;
  // reset values and limits
  localparam logic [2:0] MTS_CTRL_RST = 3'h1;
  localparam logic [13:0] MTS_DELAY_RST = 14'h0000;
  localparam logic [13:0] MTS_DELAY_MAX = 14'h270f;
  // timing
  localparam int MTS_MS_NS = 1000000;
  localparam int MTS_CLK_NS = 10;
  localparam int MTS_SETTLE_MS = 100;
  // characters of the result string
  localparam logic [7:0] MTS_CH_NUL = 8'h00;
  localparam logic [7:0] MTS_CH_BLANK = 8'h20;
  localparam logic [7:0] MTS_CH_PLUS = 8'h2b;
  localparam logic [7:0] MTS_CH_MINUS = 8'h2d;
  localparam logic [7:0] MTS_CH_POINT = 8'h2e;
  localparam logic [7:0] MTS_CH_ZERO = 8'h30;
  localparam logic [7:0] MTS_CH_ONE = 8'h31;
  localparam logic [7:0] MTS_CH_EXP = 8'h45;
  // overflow and fault codes: mantissa 1 then zeros, exponent base minus int digits
  localparam logic [23:0] MTS_OVF_DIGITS = 24'h100000;
  localparam logic [3:0] MTS_OVF_EXP_BASE = 4'ha;
  localparam logic [3:0] MTS_FLT_EXP_BASE = 4'hb;
  localparam logic [3:0] MTS_EXP_TWO_DIG = 4'ha;
  // digits left of the point per layout select
  localparam logic [2:0] MTS_NINT_24 = 3'h2;
  localparam logic [2:0] MTS_NINT_33 = 3'h3;
  localparam logic [2:0] MTS_NINT_42 = 3'h4;
  localparam logic [2:0] MTS_NINT_15 = 3'h1;

  typedef enum logic [2:0] {
    MTS_IDLE = 3'h0,
    MTS_WAIT = 3'h1,
    MTS_DELAY = 3'h3,
    MTS_MEAS = 3'h2,
    MTS_CALC = 3'h6,
    MTS_OUTP = 3'h7
  } mts_state_t;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic fault;
    logic [23:0] digits;
    logic expNeg;
    logic [3:0] expDig;
  } mts_meas_t;

  typedef struct packed {
    logic delayEn;
    logic extSrc;
    logic contMode;
  } mts_ctrl_t;
endpackage

// File: rtl/mts_trigger_seq.sv
// Purpose: trigger sequencer with AHB-Lite registers and result formatter
// Assumes: single AHB-Lite slave, engine answers start with a done pulse
// Notes: all state freezes while ce is low
// Functional notes
// - continuous internal source free-runs automatically
// - continuous external waits terminal, key, command
// - one-shot mode returns to idle after measuring
// - idle ignores every trigger source
// - arm command moves idle to trigger-wait
// - arm in continuous mode flags execution error
// - armed internal one-shot triggers at once
// - armed external one-shot takes one measurement
// - continuous off only remotely, forced on otherwise
// - source selects internal or external, lights indicator
// - measure-and-read wait ignores trigger command
// - delay enable inserts programmed delay before measuring
// - delay programmable 0 to 9999 ms, readable
// - fetch returns latest result without triggering
// - measure-and-read arms and returns next result
// - measure-and-read in continuous mode is error
// - hold following commands until measurement finishes
// - resistance layouts with overflow and fault codes
// - lowest voltage fault uses two exponent digits
// - relative values use three-plus-three layout
// - positive results show blank sign
// - leading zeros before point become blanks, except the digit next to the point
`timescale 1ns/1ps
module mts_trigger_seq import mts_pkg::*; #(
  parameter int unsigned MS_CYC = MTS_MS_NS / MTS_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic remoteActive,
  input wire logic trigTerminal,
  input wire logic frontKey,
  output logic extTrigIndicator,
  output logic measStart,
  input wire logic measDone,
  input wire mts_meas_t measResult,
  input wire logic [1:0] layoutSel,
  input wire logic relMode,
  output logic resultStrobe
);

  mts_state_t stateQ, stateD;
  mts_ctrl_t ctrlQ;
  mts_meas_t measQ, rawQ;
  logic [13:0] delayQ;
  logic [13:0] dlyCntQ;
  logic [19:0] preQ;
  logic [2:0] nIntQ;
  logic [95:0] strQ;
  logic [7:0] dAddrQ;
  logic dWriteQ, dPhaseQ, hreadyQ, hrespQ;
  logic [31:0] hrdataQ;
  logic execErrQ, readPendQ, measStartQ, strobeQ, extLedQ;
  logic termQ, keyQ;

  // result string builder: sign, six digits with point, E, exponent sign and digits
  function automatic logic [95:0] fmtStr(input mts_meas_t m, input logic [2:0] nInt);
    logic [11:0][7:0] b;
    logic [23:0] dg;
    logic [3:0] ev;
    logic [3:0] d;
    logic blank;
    int p;
    b = {12{MTS_CH_NUL}};
    blank = 1'b1;
    dg = (m.ovf | m.fault) ? MTS_OVF_DIGITS : m.digits;
    if (m.fault) begin
      ev = MTS_FLT_EXP_BASE - {1'b0, nInt};
    end else if (m.ovf) begin
      ev = MTS_OVF_EXP_BASE - {1'b0, nInt};
    end else begin
      ev = m.expDig;
    end
    b[0] = (m.neg && !m.fault) ? MTS_CH_MINUS : MTS_CH_BLANK;
    for (int i = 0; i < 6; i++) begin
      d = dg[23 - 4 * i -: 4];
      p = 1 + i + ((i >= int'(nInt)) ? 1 : 0);
      if (blank && d == 4'h0 && i < int'(nInt) - 1) begin
        b[p] = MTS_CH_BLANK;
      end else begin
        b[p] = MTS_CH_ZERO + {4'h0, d};
        blank = 1'b0;
      end
    end
    b[1 + int'(nInt)] = MTS_CH_POINT;
    b[8] = MTS_CH_EXP;
    b[9] = (m.expNeg && !(m.ovf || m.fault)) ? MTS_CH_MINUS : MTS_CH_PLUS;
    // a fault in the one-digit layout reaches exponent 10 and needs two digits
    if (ev >= MTS_EXP_TWO_DIG) begin
      b[10] = MTS_CH_ONE;
      b[11] = MTS_CH_ZERO + {4'h0, ev - MTS_EXP_TWO_DIG};
    end else begin
      b[10] = MTS_CH_ZERO + {4'h0, ev};
    end
    return b;
  endfunction

  // bus decode: a data phase completes only when no measure-and-read is pending
  wire addrPhase = hsel & htrans[1] & hready;
  wire dataDone = dPhaseQ & ~readPendQ;
  wire busWr = dataDone & dWriteQ;
  wire wrCtrl = busWr & (dAddrQ == MTS_OFS_CTRL);
  wire wrDelay = busWr & (dAddrQ == MTS_OFS_DELAY);
  wire wrCmd = busWr & (dAddrQ == MTS_OFS_CMD);
  wire cmdArm = wrCmd & hwdata[MTS_CMD_ARM];
  wire cmdFire = wrCmd & hwdata[MTS_CMD_FIRE];
  wire cmdRead = wrCmd & hwdata[MTS_CMD_READ];
  wire cmdClr = wrCmd & hwdata[MTS_CMD_CLR];
  wire over = (|hwdata[31:14]) | (hwdata[13:0] > MTS_DELAY_MAX);
  wire [13:0] delayIn = over ? MTS_DELAY_MAX : hwdata[13:0];

  // trigger qualification; inputs are synchronous so one flop gives the edge
  wire termEdge = trigTerminal & ~termQ;
  wire keyEdge = frontKey & ~keyQ;
  wire extFire = termEdge | keyEdge | (cmdFire & ~readPendQ);
  wire fireOk = (stateQ == MTS_WAIT) & (ctrlQ.extSrc ? extFire : 1'b1);
  wire errSet = (cmdArm | cmdRead) & ctrlQ.contMode;
  wire msTick = (preQ == 20'(MS_CYC - 1));

  // layout select: relative values always use the three-plus-three layout
  wire [2:0] nIntSel = relMode ? MTS_NINT_33 :
    (layoutSel == 2'h0) ? MTS_NINT_24 :
    (layoutSel == 2'h1) ? MTS_NINT_33 :
    (layoutSel == 2'h2) ? MTS_NINT_42 : MTS_NINT_15;

  // read-back mux; fetch reads the stored string and never triggers
  wire [31:0] statWord = {26'h0, measStartQ, readPendQ, execErrQ, stateQ};
  wire [31:0] rdMux =
    (dAddrQ == MTS_OFS_CTRL) ? {29'h0, ctrlQ} :
    (dAddrQ == MTS_OFS_DELAY) ? {18'h0, delayQ} :
    (dAddrQ == MTS_OFS_STAT) ? statWord :
    (dAddrQ == MTS_OFS_STR0) ? strQ[31:0] :
    (dAddrQ == MTS_OFS_STR1) ? strQ[63:32] :
    (dAddrQ == MTS_OFS_STR2) ? strQ[95:64] :
    (dAddrQ == MTS_OFS_RAW) ? rawQ : 32'h0;

  // sequencer next state
  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      MTS_IDLE: begin
        // continuous mode never rests in idle; from reset it starts waiting at once
        if (ctrlQ.contMode) begin
          stateD = MTS_WAIT;
        end else if (cmdArm | cmdRead) begin
          stateD = MTS_WAIT;
        end
      end
      MTS_WAIT: begin
        if (fireOk) begin
          stateD = ctrlQ.delayEn ? MTS_DELAY : MTS_MEAS;
        end
      end
      MTS_DELAY: begin
        if (dlyCntQ == 14'h0) begin
          stateD = MTS_MEAS;
        end
      end
      MTS_MEAS: begin
        if (measDone) begin
          stateD = MTS_CALC;
        end
      end
      MTS_CALC: stateD = MTS_OUTP;
      MTS_OUTP: stateD = ctrlQ.contMode ? MTS_WAIT : MTS_IDLE;
      default: stateD = MTS_IDLE;
    endcase
  end

  // bus slave: one wait state per transfer, longer while a read is pending
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dPhaseQ <= 1'b0;
      dWriteQ <= 1'b0;
      dAddrQ <= 8'h0;
      hreadyQ <= 1'b1;
      hrespQ <= 1'b0;
      hrdataQ <= 32'h0;
    end else if (ce) begin
      if (addrPhase) begin
        dPhaseQ <= 1'b1;
        dWriteQ <= hwrite & (hsize == MTS_HSIZE_WORD);
        dAddrQ <= haddr[7:0];
        hreadyQ <= 1'b0;
      end else if (dataDone) begin
        dPhaseQ <= 1'b0;
        hreadyQ <= 1'b1;
        hrdataQ <= rdMux;
      end
    end
  end

  // control registers; continuous off sticks only under remote control
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlQ <= MTS_CTRL_RST;
      delayQ <= MTS_DELAY_RST;
      execErrQ <= 1'b0;
    end else if (ce) begin
      if (wrCtrl) begin
        ctrlQ.extSrc <= hwdata[MTS_CTRL_EXT];
        ctrlQ.delayEn <= hwdata[MTS_CTRL_DLY];
      end
      if (!remoteActive) begin
        ctrlQ.contMode <= 1'b1;
      end else if (wrCtrl) begin
        ctrlQ.contMode <= hwdata[MTS_CTRL_CONT];
      end
      if (wrDelay) begin
        delayQ <= delayIn;
      end
      execErrQ <= errSet | (execErrQ & ~cmdClr); // set wins over clear
    end
  end

  // sequencer state, pending read and trigger edge memory
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stateQ <= MTS_IDLE;
      readPendQ <= 1'b0;
      termQ <= 1'b0;
      keyQ <= 1'b0;
    end else if (ce) begin
      stateQ <= stateD;
      termQ <= trigTerminal;
      keyQ <= frontKey;
      if (cmdRead & ~ctrlQ.contMode) begin
        readPendQ <= 1'b1;
      end else if (stateQ == MTS_OUTP) begin
        readPendQ <= 1'b0;
      end
    end
  end

  // delay timer: prescaler and count reload on every accepted trigger
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      preQ <= 20'h0;
      dlyCntQ <= 14'h0;
    end else if (ce) begin
      if (fireOk) begin
        preQ <= 20'h0;
        dlyCntQ <= delayQ;
      end else if (stateQ == MTS_DELAY) begin
        preQ <= msTick ? 20'h0 : preQ + 20'h1;
        if (msTick && dlyCntQ != 14'h0) begin
          dlyCntQ <= dlyCntQ - 14'h1;
        end
      end
    end
  end

  // engine handshake, result capture and formatting
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      measStartQ <= 1'b0;
      measQ <= '0;
      rawQ <= '0;
      nIntQ <= MTS_NINT_24;
      strQ <= {12{MTS_CH_NUL}};
      strobeQ <= 1'b0;
      extLedQ <= 1'b0;
    end else if (ce) begin
      extLedQ <= ctrlQ.extSrc;
      strobeQ <= (stateQ == MTS_CALC);
      if (stateQ == MTS_MEAS && measDone) begin
        measStartQ <= 1'b0;
        measQ <= measResult;
        nIntQ <= nIntSel;
      end else if (stateD == MTS_MEAS && stateQ != MTS_MEAS) begin
        measStartQ <= 1'b1;
      end
      // latest store changes only after the done handshake
      if (stateQ == MTS_CALC) begin
        strQ <= fmtStr(measQ, nIntQ);
        rawQ <= measQ;
      end
    end
  end

  assign hreadyout = hreadyQ;
  assign hresp = hrespQ;
  assign hrdata = hrdataQ;
  assign extTrigIndicator = extLedQ;
  assign measStart = measStartQ;
  assign resultStrobe = strobeQ;

  // checks; an attempt is dropped while the clock enable is low
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn || !ce);

  property p_idle_ignores;
    stateQ == MTS_IDLE && !ctrlQ.contMode && !cmdArm && !cmdRead |=> stateQ == MTS_IDLE;
  endproperty
  a_idle_ignores: assert property (p_idle_ignores) else $error("idle left without arm");

  property p_cont_wait;
    stateQ == MTS_IDLE && ctrlQ.contMode |=> stateQ == MTS_WAIT;
  endproperty
  a_cont_wait: assert property (p_cont_wait) else $error("idle kept in continuous");

  property p_arm_wait;
    stateQ == MTS_IDLE && cmdArm && !ctrlQ.contMode |=> stateQ == MTS_WAIT;
  endproperty
  a_arm_wait: assert property (p_arm_wait) else $error("arm did not leave idle");

  property p_ext_wait;
    stateQ == MTS_WAIT && ctrlQ.extSrc && !termEdge && !keyEdge && !cmdFire |=> stateQ == MTS_WAIT;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("external wait left untriggered");

  property p_handshake;
    stateQ == MTS_CALC |=> stateQ == MTS_OUTP && strobeQ && !measStartQ;
  endproperty
  a_handshake: assert property (p_handshake) else $error("output step missed");

  property p_free_run;
    stateQ == MTS_OUTP && ctrlQ.contMode && !ctrlQ.extSrc && !wrCtrl
      |=> stateQ == MTS_WAIT ##1 (stateQ == MTS_DELAY || stateQ == MTS_MEAS);
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run did not restart");

  property p_oneshot_idle;
    stateQ == MTS_OUTP && !ctrlQ.contMode |=> stateQ == MTS_IDLE;
  endproperty
  a_oneshot_idle: assert property (p_oneshot_idle) else $error("one-shot not back to idle");

  property p_arm_err;
    // the refused arm must never drag a running sequence back into trigger-wait
    cmdArm && ctrlQ.contMode && stateQ != MTS_IDLE && stateQ != MTS_OUTP
      |=> execErrQ && (stateQ != MTS_WAIT || $past(stateQ) == MTS_WAIT);
  endproperty
  a_arm_err: assert property (p_arm_err) else $error("arm in continuous mode no error");

  property p_cmd_blocked;
    stateQ == MTS_WAIT && readPendQ && ctrlQ.extSrc && !termEdge && !keyEdge
      |=> stateQ == MTS_WAIT;
  endproperty
  a_cmd_blocked: assert property (p_cmd_blocked) else $error("command fired a read wait");

  property p_holdoff;
    readPendQ && dPhaseQ |=> !hreadyQ;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("bus answered during pending read");

  property p_cont_forced;
    !remoteActive |=> ctrlQ.contMode;
  endproperty
  a_cont_forced: assert property (p_cont_forced) else $error("continuous not forced on");

  property p_no_delay;
    fireOk && !ctrlQ.delayEn |=> stateQ == MTS_MEAS ##0 measStartQ;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("undelayed trigger did not measure");

  property p_sign_blank;
    stateQ == MTS_CALC && !measQ.neg |=> strQ[7:0] == MTS_CH_BLANK && strobeQ;
  endproperty
  a_sign_blank: assert property (p_sign_blank) else $error("positive sign not blank");

  property p_led;
    $changed(ctrlQ.extSrc) |=> extLedQ == $past(ctrlQ.extSrc);
  endproperty
  a_led: assert property (p_led) else $error("indicator does not follow source");

endmodule

// File: tb/mts_engine_model.sv
// Purpose: behavioural measurement engine facing the sequencer
// Assumes: measStart is a level held until the cycle after measDone
// Notes: latency is a port so the bench can answer promptly or slowly
`timescale 1ns/1ps
module mts_engine_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] latency,
  input wire logic measStart,
  output logic measDone
);
  logic [4:0] cnt_q;
  // one done pulse per start, only while start is high
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 5'h00;
      measDone <= 1'b0;
    end else begin
      measDone <= 1'b0;
      if (!measStart) begin
        cnt_q <= 5'h00;
      end else if (cnt_q < {1'b0, latency}) begin
        cnt_q <= cnt_q + 5'h01;
      end else if (cnt_q == {1'b0, latency}) begin
        measDone <= 1'b1;
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench of the trigger sequencer
// Assumes: MS_CYC shortened to 10 cycles per millisecond
// Notes: bus tasks hold each phase until hready is seen high
`timescale 1ns/1ps
module testbench import mts_pkg::*;;
  logic sys_clk, resetn, ce, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, layoutSel;
  logic [2:0] hsize;
  logic remoteActive, trigTerminal, frontKey, extTrigIndicator;
  logic measStart, measDone, relMode, resultStrobe;
  logic [3:0] lat;
  mts_meas_t measResult;
  int err_count, n_tests, nStrobe, cyc, s, t0;

  mts_trigger_seq #(.MS_CYC(10)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .remoteActive(remoteActive), .trigTerminal(trigTerminal),
    .frontKey(frontKey), .extTrigIndicator(extTrigIndicator), .measStart(measStart),
    .measDone(measDone), .measResult(measResult), .layoutSel(layoutSel),
    .relMode(relMode), .resultStrobe(resultStrobe));
  mts_engine_model u_eng (.sys_clk(sys_clk), .resetn(resetn), .latency(lat),
    .measStart(measStart), .measDone(measDone));

  always #5 sys_clk = ~sys_clk;
  // strobe counter and watchdog; a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (resultStrobe === 1'b1) nStrobe <= nStrobe + 1;
    if (cyc > 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  // single word transfer; read data taken at the edge hready is seen high
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
    chk(hresp, 1'b0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h00000000);
  endtask
  task automatic poll_idle();
    rd(MTS_OFS_STAT);
    while (r[2:0] !== 3'h0) rd(MTS_OFS_STAT);
  endtask
  task automatic edge_in(input logic key);
    if (key) frontKey <= 1'b1; else trigTerminal <= 1'b1;
    repeat (2) @(posedge sys_clk);
    frontKey <= 1'b0;
    trigTerminal <= 1'b0;
  endtask
  task automatic chk_str(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    rd(MTS_OFS_STR0); chk(r, a);
    rd(MTS_OFS_STR1); chk(r, b);
    rd(MTS_OFS_STR2); chk(r, c);
  endtask

  // reset values, refused commands in continuous mode, local forcing
  task automatic t_reset();
    rd(MTS_OFS_CTRL); chk(r, 32'h1);
    rd(MTS_OFS_DELAY); chk(r, 32'h0);
    wr(MTS_OFS_CMD, 32'h1);
    rd(MTS_OFS_STAT); chk(r[4:3], 2'h1);
    wr(MTS_OFS_CMD, 32'h8);
    wr(MTS_OFS_CMD, 32'h4);
    rd(MTS_OFS_STAT); chk(r[4:3], 2'h1);
    wr(MTS_OFS_CMD, 32'h8);
    wr(MTS_OFS_CTRL, 32'h0);
    rd(MTS_OFS_CTRL); chk(r, 32'h1);
  endtask
  // one-shot internal: idle ignores edges, arm measures once, blanked string
  task automatic t_oneshot();
    remoteActive <= 1'b1;
    wr(MTS_OFS_CTRL, 32'h0);
    rd(MTS_OFS_CTRL); chk(r, 32'h0);
    // the free run started at reset finishes its cycle before idle is reached
    poll_idle();
    measResult <= mts_meas_t'({3'b000, 24'h001360, 1'b1, 4'h3});
    layoutSel <= 2'h2;
    s = nStrobe;
    edge_in(1'b0);
    edge_in(1'b1);
    repeat (20) @(posedge sys_clk);
    chk(nStrobe, s);
    wr(MTS_OFS_CMD, 32'h1);
    poll_idle();
    chk(nStrobe, s + 1);
    chk_str(32'h31202020, 32'h30362e33, 32'h00332d45);
  endtask
  // measure-and-read with a slow engine, fault code, fetch without trigger
  task automatic t_readq();
    lat <= 4'h9;
    measResult <= mts_meas_t'({3'b001, 24'h000000, 5'h00});
    layoutSel <= 2'h0;
    s = nStrobe;
    repeat (MTS_SETTLE_MS * 10) @(posedge sys_clk);
    wr(MTS_OFS_CMD, 32'h4);
    rd(MTS_OFS_STAT); chk(r, 32'h0);
    chk(nStrobe, s + 1);
    chk_str(32'h2e303120, 32'h30303030, 32'h00392b45);
    rd(MTS_OFS_RAW); chk(r, 32'h20000000);
    repeat (10) @(posedge sys_clk);
    chk(nStrobe, s + 1);
  endtask
  // external one-shot: indicator, wait, command trigger, key for read query
  task automatic t_ext();
    lat <= 4'h1;
    layoutSel <= 2'h3;
    wr(MTS_OFS_CTRL, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk(extTrigIndicator, 1'b1);
    s = nStrobe;
    wr(MTS_OFS_CMD, 32'h1);
    repeat (10) @(posedge sys_clk);
    rd(MTS_OFS_STAT); chk(r, 32'h1);
    wr(MTS_OFS_CMD, 32'h2);
    poll_idle();
    edge_in(1'b0);
    repeat (10) @(posedge sys_clk);
    chk(nStrobe, s + 1);
    chk_str(32'h302e3120, 32'h30303030, 32'h30312b45);
    relMode <= 1'b1;
    measResult <= mts_meas_t'({3'b110, 29'h00000000});
    repeat (MTS_SETTLE_MS * 10) @(posedge sys_clk);
    wr(MTS_OFS_CMD, 32'h4);
    edge_in(1'b1);
    rd(MTS_OFS_STAT); chk(r, 32'h0);
    chk(nStrobe, s + 2);
    chk_str(32'h3030312d, 32'h3030302e, 32'h00372b45);
    relMode <= 1'b0;
  endtask
  // delay clamp and the gap from arm to measurement, with and without delay
  task automatic t_delay();
    layoutSel <= 2'h1;
    measResult <= mts_meas_t'({3'b100, 24'h007510, 5'h00});
    wr(MTS_OFS_DELAY, 32'h0000ffff);
    rd(MTS_OFS_DELAY); chk(r, 32'h270f);
    wr(MTS_OFS_DELAY, 32'h3);
    for (int e = 1; e >= 0; e--) begin
      wr(MTS_OFS_CTRL, e ? 32'h4 : 32'h0);
      t0 = cyc;
      wr(MTS_OFS_CMD, 32'h1);
      while (measStart !== 1'b1) @(posedge sys_clk);
      chk((cyc - t0 >= (e ? 30 : 0)) && (cyc - t0 <= (e ? 40 : 8)), 1'b1);
      poll_idle();
    end
    chk_str(32'h3720202d, 32'h3031352e, 32'h00302b45);
  endtask
  // continuous: free-run internal, then external returns to trigger-wait
  task automatic t_cont();
    wr(MTS_OFS_CTRL, 32'h1);
    s = nStrobe;
    repeat (100) @(posedge sys_clk);
    chk(nStrobe - s >= 2, 1'b1);
    wr(MTS_OFS_CTRL, 32'h3);
    repeat (20) @(posedge sys_clk);
    s = nStrobe;
    edge_in(1'b0);
    repeat (20) @(posedge sys_clk);
    chk(nStrobe, s + 1);
    rd(MTS_OFS_STAT); chk(r[2:0], 3'h1);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    {sys_clk, resetn, hsel, hwrite, remoteActive, trigTerminal, frontKey, relMode} = '0;
    {haddr, hwdata, htrans, layoutSel, cyc, nStrobe, err_count, n_tests} = '0;
    ce = 1'b1;
    hsize = MTS_HSIZE_WORD;
    measResult = '0;
    lat = 4'h4;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_oneshot();
    t_readq();
    t_ext();
    t_delay();
    t_cont();
    tally_and_finish();
  end
endmodule
